// ==== dv/drc_host_model.sv ====
// memory controller model issuing refresh and mode commands
// assumes mclk_in is the device clock; the testbench calls its tasks
`timescale 1ns/1ps
module drc_host_model
  import drc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic extended_range_in,
  input wire logic [7:0] case_temperature_in,
  output drc_cmd_t cmd_out
);
  // longest average spacing at full rate, in device clock cycles
  localparam int REFI_BASE_CYC = 7800000 / CLK_PERIOD_PS;
  // halvings of the spacing for the extended range and for case heat
  function automatic int heat_shift();
    heat_shift = 0;
    if ($signed(case_temperature_in) > 8'sh69) begin
      heat_shift = 3;
    end else if ($signed(case_temperature_in) > 8'sh5F) begin
      heat_shift = 2;
    end else if ($signed(case_temperature_in) >= 8'sh55 || extended_range_in) begin
      heat_shift = 1;
    end
  endfunction
  initial cmd_out = {1'b1, 26'h0};
  // one command, then deselect with pins churning so stale values never pass
  task automatic send(input logic we_n, input logic [2:0] f, input logic b, input int gap);
    @(posedge mclk_in);
    cmd_out <= {4'h4, we_n, we_n & 1'($urandom), b, 2'h3, 9'($urandom), f, 6'($urandom)};
    repeat (gap) begin
      @(posedge mclk_in);
      cmd_out <= {1'b1, 26'($urandom)};
    end
  endtask
  // mode write, issued before any rate-selecting refresh
  task automatic mode_register_set(input logic [2:0] f);
    send(1'b0, f, 1'b0, 4);
  endtask
  // refresh held off for its rate's cycle time plus random slack
  // and never spaced wider than the interval that rate, range and heat allow
  task automatic refresh(input logic b, input logic [1:0] r);
    int gap;
    int lim;
    gap = 1 + $urandom_range(3) + (r == RATE_4X ? RFC_QUAD_CYC :
      r == RATE_2X ? RFC_DOUBLE_CYC : RFC_FULL_CYC);
    lim = (REFI_BASE_CYC >> r) >> heat_shift();
    send(1'b1, 3'($urandom), b, gap < lim ? gap : lim - 1);
  endtask
endmodule

// ==== dv/drc_props.sv ====
// assertions on the refresh-rate control ports
// assumes a bind onto drc_refresh_ctrl, one clock, sync reset
`timescale 1ns/1ps
module drc_props
  import drc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire drc_cmd_t cmd_in,
  input wire logic temp_controlled_refresh_in,
  input wire drc_reg_req_t reg_in,
  input wire logic int_refresh_out,
  input wire logic [1:0] int_rate_out,
  input wire logic refresh_busy_out,
  input wire logic [2:0] fine_grain_refresh_out,
  input wire logic illegal_out
);
  logic [2:0] m;
  logic [4:0] p;
  logic [1:0] er;
  logic [5:0] bc;
  logic rf;
  logic ms;
  // strobe decode only, address pins never matter for a refresh
  assign m = fine_grain_refresh_out;
  assign p = {cmd_in.cs_n, cmd_in.activate_n, cmd_in.ras_n, cmd_in.cas_n, cmd_in.we_n};
  assign rf = p == 5'h09;
  assign ms = p == 5'h08 && !cmd_in.bg[1] && cmd_in.ba == 2'h3;
  // rate that mode and rate bit call for
  assign er = (m == FGR_FIXED_2X || m == FGR_OTF_1X2X && cmd_in.bg[0]) ? RATE_2X :
    (m == FGR_FIXED_4X || m == FGR_OTF_1X4X && cmd_in.bg[0]) ? RATE_4X : RATE_1X;
  // busy run length, read where busy falls
  always_ff @(posedge mclk_in) bc <= (rst_in || !refresh_busy_out) ? 6'h0 : bc + 6'h1;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  sequence s_go;
    rf && !refresh_busy_out && (!temp_controlled_refresh_in || m != FGR_FIXED_1X);
  endsequence
  sequence s_run;
    int_refresh_out && refresh_busy_out && int_rate_out == $past(er);
  endsequence
  rate_pick_a: assert property (s_go |=> s_run)
    else $error("wrong refresh run");
  pulse_cause_a: assert property (int_refresh_out |-> $past(rf))
    else $error("pulse without refresh");
  busy_len_a: assert property ($fell(refresh_busy_out) |-> bc ==
    (int_rate_out == RATE_4X ? RFC_QUAD_CYC : int_rate_out == RATE_2X ?
    RFC_DOUBLE_CYC : RFC_FULL_CYC)) else $error("busy length wrong");
  mode_write_a: assert property (ms |=> m == $past(cmd_in.addr[8:6]))
    else $error("mode not written");
  mode_hold_a: assert property (!ms |=> $stable(m))
    else $error("mode moved");
  reserved_flag_a: assert property (rf && m inside {3'h3, 3'h4, 3'h7} |->
    ##[1:2] illegal_out) else $error("reserved mode not flagged");
  tcr_flag_a: assert property (rf && temp_controlled_refresh_in && m != 3'h0 |->
    ##[1:2] illegal_out) else $error("skip with fine mode not flagged");
  flag_hold_a: assert property (illegal_out && !(reg_in.wr && reg_in.addr == OFS_CTRL
    && reg_in.wdata[CTRL_CLR_ERR]) |=> illegal_out) else $error("flag dropped");
endmodule
bind drc_refresh_ctrl drc_props drc_props_i (.*);

// ==== dv/testbench.sv ====
// self-checking bench for the refresh-rate control block
// assumes the partner model drives the command pins
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin bad_count++; \
  $display("[ERR] %s expected %0h seen %0h", n, e, s); end end
module testbench;
  import drc_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic temp_controlled_refresh = 1'b0;
  logic ext = 1'b0;
  logic [7:0] temp = TEMP_RESET;
  drc_reg_req_t reg_in = '0;
  drc_cmd_t cmd;
  logic [31:0] rdata;
  logic [31:0] dv;
  logic pulse, busy, ill;
  logic rd_d = 1'b0;
  logic [1:0] rate;
  logic [1:0] ev;
  logic [2:0] fgr;
  logic [1:0] rq[$];
  logic [31:0] dq[$];
  int bad_count = 0;
  int compares = 0;
  int npulse = 0;
  logic [2:0] modes[5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
  logic [1:0] rt[2][5] = '{'{RATE_1X, RATE_2X, RATE_4X, RATE_1X, RATE_1X},
    '{RATE_1X, RATE_2X, RATE_4X, RATE_2X, RATE_4X}};
  // skip off and range, temperature, runs out of eight refreshes
  logic [13:0] sk[6] = '{{2'h0, 8'h1E, 4'h4}, {2'h1, 8'h1E, 4'h2}, {2'h1, 8'h3C, 4'h4},
    {2'h0, 8'h3C, 4'h8}, {2'h1, 8'h5A, 4'h8}, {2'h3, 8'h1E, 4'h8}};
  always #5 mclk_in = ~mclk_in;
  drc_refresh_ctrl drc_refresh_ctrl_i (.mclk_in(mclk_in), .rst_in(rst_in), .cmd_in(cmd),
    .temp_controlled_refresh_in(temp_controlled_refresh), .extended_range_in(ext), .case_temperature_in(temp),
    .reg_in(reg_in), .reg_rdata_out(rdata), .int_refresh_out(pulse), .int_rate_out(rate),
    .refresh_busy_out(busy), .fine_grain_refresh_out(fgr), .illegal_out(ill));
  drc_host_model drc_host_model_i (.mclk_in(mclk_in), .extended_range_in(ext),
    .case_temperature_in(temp), .cmd_out(cmd));
  // register write; the extra edge lets its effect land
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    reg_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_in);
    reg_in.wr <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    dq.push_back(e);
    @(posedge mclk_in);
    reg_in <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_in);
    reg_in.rd <= 1'b0;
    repeat (2) @(posedge mclk_in);
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // results watcher: oldest note against each pulse and read slot
  always @(posedge mclk_in) begin
    if (pulse === 1'b1) begin
      npulse++;
      if (rq.size() > 0) begin
        ev = rq.pop_front();
        `CHK("rate", ev, rate)
      end
      `CHK("busy", 1'b1, busy)
    end
    if (rd_d) begin
      dv = dq.pop_front();
      `CHK("rdata", dv, rdata)
    end
    rd_d <= reg_in.rd;
  end
  // watchdog, several times the expected run
  initial begin
    repeat (30000) @(posedge mclk_in);
    bad_count++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'hC0F65C7D));
    repeat (10) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    `CHK("mode", 3'h0, fgr)
    $display("reset done");
    // every defined mode, both rate bits, four refreshes each keeps pairing whole
    foreach (modes[i]) begin
      drc_host_model_i.mode_register_set(modes[i]);
      `CHK("mode", modes[i], fgr)
      for (int b = 0; b < 2; b++) begin
        repeat (4) begin
          rq.push_back(rt[b][i]);
          drc_host_model_i.refresh(b[0], rt[b][i]);
        end
      end
    end
    `CHK("runs", 40, npulse)
    `CHK("illegal", 1'b0, ill)
    rd(OFS_STATUS, {16'h0, TEMP_RESET, 2'h0, RATE_4X, 4'h0} | 32'(FGR_OTF_1X4X));
    $display("mode sweep done");
    drc_host_model_i.mode_register_set(3'h3);
    rq.push_back(RATE_1X);
    drc_host_model_i.refresh(1'b0, RATE_1X);
    `CHK("illegal", 1'b1, ill)
    wr(OFS_CTRL, 32'h4);
    `CHK("illegal", 1'b0, ill)
    rd(4'h2, 32'h0);
    drc_host_model_i.mode_register_set(FGR_FIXED_1X);
    $display("reserved mode done");
    temp_controlled_refresh <= 1'b1;
    foreach (sk[i]) begin
      {ext, temp} <= sk[i][12:4];
      wr(OFS_CTRL, {30'h0, 1'b1, sk[i][13]});
      npulse = 0;
      repeat (8) drc_host_model_i.refresh(1'b0, RATE_1X);
      `CHK("runs", 32'(sk[i][3:0]), npulse)
      rd(OFS_SKIP_CNT, {28'h0, 4'h8 - sk[i][3:0]});
      rd(OFS_REF_CNT, 32'(sk[i][3:0]));
    end
    $display("skip table done");
    drc_host_model_i.mode_register_set(FGR_FIXED_2X);
    rq.push_back(RATE_2X);
    drc_host_model_i.refresh(1'b0, RATE_2X);
    `CHK("illegal", 1'b1, ill)
    $display("skip with fine mode done");
    report_and_stop();
  end
endmodule

// ==== rtl/drc_pkg.sv ====
// shared constants and types for the refresh-rate control block
// assumes a single 100 MHz device clock for every user of this package
package drc_pkg;
  // clock and refresh cycle times
  localparam int CLK_PERIOD_PS = 10000;
  localparam int RFC_FULL_NS = 350;
  localparam int RFC_DOUBLE_NS = 260;
  localparam int RFC_QUAD_NS = 160;
  // least times round up to whole cycles
  localparam int RFC_FULL_CYC = (RFC_FULL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RFC_DOUBLE_CYC = (RFC_DOUBLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RFC_QUAD_CYC = (RFC_QUAD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int BUSY_W = 6;

  // fine grain refresh field of mode register three
  localparam int FGR_LSB = 6;
  localparam logic [2:0] FGR_FIXED_1X = 3'h0;
  localparam logic [2:0] FGR_FIXED_2X = 3'h1;
  localparam logic [2:0] FGR_FIXED_4X = 3'h2;
  localparam logic [2:0] FGR_OTF_1X2X = 3'h5;
  localparam logic [2:0] FGR_OTF_1X4X = 3'h6;
  localparam logic [2:0] FGR_RESET = FGR_FIXED_1X;
  localparam logic [1:0] MR_SEL_THREE = 2'h3;

  // refresh rate encoding
  localparam logic [1:0] RATE_1X = 2'h0;
  localparam logic [1:0] RATE_2X = 2'h1;
  localparam logic [1:0] RATE_4X = 2'h2;

  // temperature thresholds and reset reading in degrees celsius
  localparam logic signed [7:0] TEMP_COLD = 8'sh2D;
  localparam logic signed [7:0] TEMP_HOT = 8'sh55;
  localparam logic [7:0] TEMP_RESET = 8'h19;

  // register port map
  localparam int REG_AW = 4;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_REF_CNT = 4'h8;
  localparam logic [3:0] OFS_SKIP_CNT = 4'hC;
  localparam int CTRL_SKIP_DIS = 0;
  localparam int CTRL_CLR_CNT = 1;
  localparam int CTRL_CLR_ERR = 2;

  // command bus pins sampled on the device clock
  typedef struct packed {
    logic cs_n;
    logic activate_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bg;
    logic [1:0] ba;
    logic [17:0] addr;
  } drc_cmd_t;

  // register port request
  typedef struct packed {
    logic [REG_AW-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } drc_reg_req_t;

  // whole state of the control block
  typedef struct packed {
    logic [2:0] mode;
    logic [BUSY_W-1:0] busy;
    logic [1:0] gear;
    logic [1:0] frac;
    logic [15:0] ref_cnt;
    logic [15:0] skip_cnt;
    logic illegal;
    logic skip_dis;
    logic [7:0] temp;
    logic int_ref;
    logic [1:0] int_rate;
    logic [31:0] rd_data;
  } drc_state_t;
endpackage

// ==== rtl/drc_refresh_ctrl.sv ====
// refresh-rate control: decodes refresh and mode commands, picks the
// refresh rate, skips refreshes by temperature gear, times the cycle
// assumes command pins are on mclk_in, temperature comes from an async sensor
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
module drc_refresh_ctrl
  import drc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire drc_cmd_t cmd_in,
  input wire logic temp_controlled_refresh_in,
  input wire logic extended_range_in,
  input wire logic [7:0] case_temperature_in,
  input wire drc_reg_req_t reg_in,
  output logic [31:0] reg_rdata_out,
  output logic int_refresh_out,
  output logic [1:0] int_rate_out,
  output logic refresh_busy_out,
  output logic [2:0] fine_grain_refresh_out,
  output logic illegal_out
);
  drc_state_t cur;
  drc_state_t next_cur;
  logic [7:0] temp_s2;
  logic [7:0] temp_s3;

  // sensor reading crosses into the clock domain
  drc_sync #(.WIDTH(8), .RESET_VAL(TEMP_RESET)) u_temp_sync (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .d_in(case_temperature_in),
    .s2_out(temp_s2),
    .s3_out(temp_s3)
  );

  // rate of a refresh from mode and the sampled rate select bit
  function automatic logic [1:0] rate_of(input logic [2:0] mode, input logic sel);
    case (mode)
      FGR_FIXED_2X: rate_of = RATE_2X;
      FGR_FIXED_4X: rate_of = RATE_4X;
      FGR_OTF_1X2X: rate_of = sel ? RATE_2X : RATE_1X;
      FGR_OTF_1X4X: rate_of = sel ? RATE_4X : RATE_1X;
      default: rate_of = RATE_1X;
    endcase
  endfunction

  // refresh cycle time in clock cycles for a rate
  function automatic logic [BUSY_W-1:0] rfc_of(input logic [1:0] rate);
    case (rate)
      RATE_2X: rfc_of = BUSY_W'(RFC_DOUBLE_CYC);
      RATE_4X: rfc_of = BUSY_W'(RFC_QUAD_CYC);
      default: rfc_of = BUSY_W'(RFC_FULL_CYC);
    endcase
  endfunction

  // row and column strobes low under chip select with activate high;
  // the write strobe level tells a refresh from a mode register write
  function automatic logic strobes_are(input drc_cmd_t c, input logic we_n);
    strobes_are = !c.cs_n && c.activate_n && !c.ras_n && !c.cas_n && (c.we_n == we_n);
  endfunction

  // granularity codes with no defined refresh mode
  function automatic logic is_reserved(input logic [2:0] mode);
    case (mode)
      FGR_FIXED_1X, FGR_FIXED_2X, FGR_FIXED_4X,
      FGR_OTF_1X2X, FGR_OTF_1X4X: is_reserved = 1'b0;
      default: is_reserved = 1'b1;
    endcase
  endfunction

  // decoded command and per-refresh decisions
  logic is_ref;
  logic is_mrs;
  logic mr3_wr;
  logic [1:0] rate;
  logic [1:0] gear_mask;
  logic gear_ok;
  logic bad;
  logic signed [7:0] temp;

  // command decode, address bits play no part in a refresh
  assign is_ref = strobes_are(cmd_in, 1'b1);
  assign is_mrs = strobes_are(cmd_in, 1'b0);
  // only a write aimed at mode register three moves the granularity field
  assign mr3_wr = is_mrs && !cmd_in.bg[1] && cmd_in.ba == MR_SEL_THREE;
  assign rate = rate_of(cur.mode, cmd_in.bg[0]);
  assign temp = signed'(cur.temp);

  // gear ratio from temperature and range; mask of skipped phases
  always_comb begin
    gear_mask = 2'h0;
    if (temp_controlled_refresh_in && !cur.skip_dis
        && cur.mode == FGR_FIXED_1X) begin
      if (temp < TEMP_COLD) begin
        gear_mask = extended_range_in ? 2'h3 : 2'h1;
      end else if (temp < TEMP_HOT && extended_range_in) begin
        gear_mask = 2'h1;
      end else begin
        gear_mask = 2'h0;
      end
    end
  end
  // gear counts every accepted refresh, so skipping stays evenly spread
  assign gear_ok = (cur.gear & gear_mask) == 2'h0;

  // refresh not allowed now: reserved mode, wrong pairing, skip mode clash
  always_comb begin
    bad = 1'b0;
    if (is_reserved(cur.mode)) begin
      bad = 1'b1;
    end
    if (rate == RATE_1X && cur.frac != 2'h0) begin
      bad = 1'b1;
    end
    if (temp_controlled_refresh_in && cur.mode != FGR_FIXED_1X) begin
      bad = 1'b1;
    end
    // a refresh inside the running cycle time
    if (cur.busy != '0) begin
      bad = 1'b1;
    end
  end

  // next state
  always_comb begin
    next_cur = cur;
    next_cur.int_ref = 1'b0;
    next_cur.rd_data = 32'h0;
    if (temp_s2 == temp_s3) begin
      next_cur.temp = temp_s3; // take reading once two stages agree
    end
    // cycle time counts down to idle
    if (cur.busy != '0) begin
      next_cur.busy = cur.busy - BUSY_W'(1);
    end
    // mode register write taken even while busy; field set by address bits
    if (mr3_wr) begin
      next_cur.mode = cmd_in.addr[FGR_LSB +: 3];
      next_cur.frac = 2'h0;
    end
    // register port writes
    if (reg_in.wr && reg_in.addr == OFS_CTRL) begin
      next_cur.skip_dis = reg_in.wdata[CTRL_SKIP_DIS];
      if (reg_in.wdata[CTRL_CLR_CNT]) begin
        next_cur.ref_cnt = 16'h0;
        next_cur.skip_cnt = 16'h0;
      end
      if (reg_in.wdata[CTRL_CLR_ERR]) begin
        next_cur.illegal = 1'b0;
      end
    end
    // refresh command: every one accepted, some run, some skipped
    if (is_ref) begin
      next_cur.gear = cur.gear + 2'h1;
      if (rate == RATE_2X) begin
        next_cur.frac = {1'b0, ~cur.frac[0]};
      end else if (rate == RATE_4X) begin
        next_cur.frac = cur.frac + 2'h1;
      end
      if (bad) begin
        next_cur.illegal = 1'b1; // set wins over a clear
      end
      if (gear_ok) begin
        next_cur.int_ref = 1'b1;
        next_cur.int_rate = rate;
        next_cur.busy = rfc_of(rate);
        next_cur.ref_cnt = cur.ref_cnt + 16'h1;
      end else begin
        next_cur.skip_cnt = cur.skip_cnt + 16'h1;
      end
    end
    // register port reads, data in the next cycle only
    if (reg_in.rd) begin
      case (reg_in.addr)
        OFS_CTRL: next_cur.rd_data = {31'h0, cur.skip_dis};
        OFS_STATUS: begin
          // mode shares the low bits with busy and pairing; software masks as needed
          next_cur.rd_data = {16'h0, cur.temp, 1'b0, cur.illegal, cur.int_rate,
            cur.frac, (cur.busy != '0), 1'b0};
          next_cur.rd_data[2:0] = next_cur.rd_data[2:0] | cur.mode;
        end
        OFS_REF_CNT: next_cur.rd_data = {16'h0, cur.ref_cnt};
        OFS_SKIP_CNT: next_cur.rd_data = {16'h0, cur.skip_cnt};
        default: next_cur.rd_data = 32'h0;
      endcase
    end
  end

  // state register with synchronous reset
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      // mode and reading start at their defaults, all else cleared
      cur <= '0;
      cur.mode <= FGR_RESET;
      cur.temp <= TEMP_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // every output straight from the state register
  assign reg_rdata_out = cur.rd_data;
  assign int_refresh_out = cur.int_ref;
  assign int_rate_out = cur.int_rate;
  assign refresh_busy_out = cur.busy != '0;
  assign fine_grain_refresh_out = cur.mode;
  assign illegal_out = cur.illegal;
endmodule

// ==== rtl/drc_sync.sv ====
// three-stage synchroniser for an asynchronous multi-bit level
// assumes the source changes slowly, so stage two and three agree soon
`timescale 1ns/1ps
module drc_sync #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] s2_out,
  output logic [WIDTH-1:0] s3_out
);
  logic [WIDTH-1:0] s1;

  // first stage feeds only the second
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s1 <= RESET_VAL;
      s2_out <= RESET_VAL;
      s3_out <= RESET_VAL;
    end else begin
      s1 <= d_in;
      s2_out <= s1;
      s3_out <= s2_out;
    end
  end
endmodule
